// File: verilog/actuator_status_config_registers.sv
// status and configuration holding registers of a fieldbus damper actuator
//
// Function
// [RQ1] relative position in hundredths of percent
// [RQ2] absolute position, 65535 without actuator
// [RQ3] relative flow only for type 2
// [RQ4] absolute flow only for flow controllers
// [RQ5] sensor reading unit follows sensor type
// [RQ6] serial number segments 1, 2, 4 readable
// [RQ7] firmware version as decimal integer
// [RQ8] status low byte faults, high service
// [RQ9] low byte flags bits 0,1,2,4; the code sets bit 4 only on fire units
// [RQ10] fire units flag bits 5 to 7
// [RQ11] high byte activity, gear, watchdog bits
// [RQ12] master writes command 4 to clear faults
// [RQ13] faults 0 and 4 survive a clear
// [RQ14] writable minimum limit 0 to 10000
// [RQ15] writable maximum limit 2000 to 10000
// [RQ16] stored sensor type, zero means none
// [RQ17] no sensor: switching input forces override
// [RQ18] sensor codes 1-4, restart after change
// [RQ19] bus silence 120 s trips fail position
// [RQ20] command register returns to none itself
// [RQ21] 16-bit words, read-only writes ignored
`timescale 1ns/1ps
`default_nettype none
`include "actuator_defines.svh"

module actuator_status_config_registers #(
  parameter logic [31:0] WDOG_CYCLES = 32'(`WDOG_CYCLES),
  parameter logic [15:0] SERIAL_PART_1 = 16'h0001, // arbitrary, as are the next three
  parameter logic [15:0] SERIAL_PART_2 = 16'h0002,
  parameter logic [15:0] SERIAL_PART_4 = 16'h0004,
  parameter logic [15:0] FIRMWARE_VERSION = 16'h0064
) (
  input wire logic core_clk,
  input wire logic rstn,
  // holding register access from the fieldbus front end
  input wire logic reg_req,
  input wire logic reg_we,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic reg_ack_q,
  output logic reg_err_q,
  output logic [15:0] reg_rdata_q,
  // measurements from the actuator core
  input wire logic [1:0] actuator_type,
  input wire logic actuator_present,
  input wire logic [15:0] rel_position_in,
  input wire logic [15:0] abs_position_in,
  input wire logic [15:0] rel_flow_in,
  input wire logic [15:0] abs_flow_in,
  input wire logic [15:0] sensor_value_in,
  // events and states from the actuator core
  input wire logic [7:0] fault_set,
  input wire logic internal_activity,
  input wire logic gear_disengaged,
  input wire logic setpoint_renewed,
  input wire logic [1:0] bus_fail_mode,
  // switching level on the analogue control pin
  input wire logic y_switch_pin,
  // configuration and actions towards the actuator core
  output logic [15:0] minimum_limit_q,
  output logic [15:0] maximum_limit_q,
  output logic [2:0] sensor_kind_q,
  output logic sensor_stale_q,
  output logic local_override_q,
  output logic [2:0] command_q,
  output logic fail_close_q,
  output logic fail_open_q
);

  // ----------------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------------
  // true for the configuration words a master may write
  function automatic logic is_writable(input logic [15:0] addr);
    logic hit;
    hit = (addr == `REG_COMMAND) || (addr == `REG_MIN_LIMIT) ||
          (addr == `REG_MAX_LIMIT) || (addr == `REG_SENSOR_KIND);
    return hit;
  endfunction

  // true for every word of the bank
  function automatic logic is_mapped(input logic [15:0] addr);
    logic hit;
    hit = is_writable(addr) ||
          ((addr >= `REG_REL_POS) && (addr <= `REG_SENSOR)) ||
          ((addr >= `REG_SERIAL_1) && (addr <= `REG_STATUS));
    return hit;
  endfunction

  // limit a percentage word to a range
  function automatic logic [15:0] clamp(input logic [15:0] v,
                                        input logic [15:0] lo);
    logic [15:0] r;
    r = v;
    if (v < lo) begin
      r = lo;
    end
    if (v > `PERCENT_FULL) begin
      r = `PERCENT_FULL;
    end
    return r;
  endfunction

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  logic write_hit;
  logic read_hit;
  logic [15:0] rdata_d;
  logic [15:0] status_word;
  logic [15:0] sensor_word;
  logic [7:0] fault_flags_q;
  logic clear_faults;
  logic fire_type;
  logic flow_type;
  logic wdog_enable;
  logic wdog_renew;
  logic wdog_tripped_q;
  logic y_meta_q;
  logic y_sync_q;

  assign fire_type = (actuator_type == actuator_pkg::ACT_FIRE);
  assign flow_type = (actuator_type == actuator_pkg::ACT_FLOW_CTRL);

  // ----------------------------------------------------------------------
  // access decode
  // ----------------------------------------------------------------------
  // writes to read-only or unmapped words change nothing
  assign write_hit = reg_req && reg_we && is_writable(reg_addr); // RQ21
  assign read_hit = reg_req && is_mapped(reg_addr);

  // ----------------------------------------------------------------------
  // answer sequencing
  // ----------------------------------------------------------------------
  // acknowledge pulse and error flag for one cycle
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      reg_ack_q <= 1'b0;
      reg_err_q <= 1'b0;
    end else begin
      reg_ack_q <= reg_req;
      reg_err_q <= reg_req && !read_hit;
    end
  end

  // read data captured with the answer, held until the next one
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata_q <= 16'h0000;
    end else if (reg_req) begin
      reg_rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------------------------------------
  // read words
  // ----------------------------------------------------------------------
  // sensor reading in the unit of the configured type
  always_comb begin
    sensor_word = sensor_value_in; // RQ5
    if (sensor_stale_q) begin
      sensor_word = `INVALID_WORD; // RQ18
    end else begin
      case (sensor_kind_q)
        actuator_pkg::SENSOR_NONE: begin
          sensor_word = 16'h0000;
        end
        actuator_pkg::SENSOR_CONTACT: begin
          sensor_word = {15'h0000, sensor_value_in[0]}; // RQ5
        end
        default: begin
          sensor_word = sensor_value_in; // RQ5
        end
      endcase
    end
  end

  // status word: low byte faults, high byte service
  always_comb begin
    status_word = 16'h0000;
    status_word[7:0] = fault_flags_q; // RQ8
    status_word[`ST_ACTIVITY] = internal_activity; // RQ11
    status_word[`ST_GEAR] = gear_disengaged; // RQ11
    status_word[`ST_WATCHDOG] = wdog_tripped_q; // RQ11
  end

  // word selected by the address
  always_comb begin
    rdata_d = 16'h0000;
    case (reg_addr)
      `REG_COMMAND: begin
        rdata_d = {13'h0000, command_q};
      end
      `REG_REL_POS: begin
        rdata_d = rel_position_in; // RQ1
      end
      `REG_ABS_POS: begin
        rdata_d = actuator_present ? abs_position_in : `INVALID_WORD; // RQ2
      end
      `REG_REL_FLOW: begin
        rdata_d = flow_type ? rel_flow_in : `INVALID_WORD; // RQ3
      end
      `REG_ABS_FLOW: begin
        rdata_d = flow_type ? abs_flow_in : `INVALID_WORD; // RQ4
      end
      `REG_SENSOR: begin
        rdata_d = sensor_word;
      end
      `REG_SERIAL_1: begin
        rdata_d = SERIAL_PART_1; // RQ6
      end
      `REG_SERIAL_2: begin
        rdata_d = SERIAL_PART_2; // RQ6
      end
      `REG_SERIAL_4: begin
        rdata_d = SERIAL_PART_4; // RQ6
      end
      `REG_FIRMWARE: begin
        rdata_d = FIRMWARE_VERSION; // RQ7
      end
      `REG_STATUS: begin
        rdata_d = status_word;
      end
      `REG_MIN_LIMIT: begin
        rdata_d = minimum_limit_q;
      end
      `REG_MAX_LIMIT: begin
        rdata_d = maximum_limit_q;
      end
      `REG_SENSOR_KIND: begin
        rdata_d = {13'h0000, sensor_kind_q};
      end
      default: begin
        rdata_d = 16'h0000;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // configuration words
  // ----------------------------------------------------------------------
  // minimum limit, kept within full travel
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      minimum_limit_q <= `MIN_LIMIT_RESET;
    end else if (write_hit && (reg_addr == `REG_MIN_LIMIT)) begin
      minimum_limit_q <= clamp(reg_wdata, 16'h0000); // RQ14
    end
  end

  // maximum limit, never below twenty percent
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      maximum_limit_q <= `MAX_LIMIT_RESET;
    end else if (write_hit && (reg_addr == `REG_MAX_LIMIT)) begin
      maximum_limit_q <= clamp(reg_wdata, `MAX_LIMIT_FLOOR); // RQ15
    end
  end

  // sensor type; unknown codes leave it unchanged
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sensor_kind_q <= `SENSOR_KIND_RESET;
    end else if (write_hit && (reg_addr == `REG_SENSOR_KIND) &&
                 (reg_wdata <= `SENSOR_KIND_LAST)) begin
      sensor_kind_q <= reg_wdata[2:0]; // RQ16 RQ18
    end
  end

  // readings invalid after a type change until the next restart
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sensor_stale_q <= 1'b0;
    end else if (write_hit && (reg_addr == `REG_SENSOR_KIND) &&
                 (reg_wdata <= `SENSOR_KIND_LAST) &&
                 (reg_wdata[2:0] != sensor_kind_q)) begin
      sensor_stale_q <= 1'b1; // RQ18
    end
  end

  // ----------------------------------------------------------------------
  // command word
  // ----------------------------------------------------------------------
  // holds a command for one cycle, then falls back to none
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      command_q <= actuator_pkg::CMD_NONE;
    end else if (write_hit && (reg_addr == `REG_COMMAND) &&
                 (reg_wdata <= 16'(actuator_pkg::CMD_RESET_FAULTS))) begin
      command_q <= reg_wdata[2:0];
    end else begin
      command_q <= actuator_pkg::CMD_NONE; // RQ20
    end
  end

  assign clear_faults = (command_q == actuator_pkg::CMD_RESET_FAULTS); // RQ12

  // ----------------------------------------------------------------------
  // malfunction flags
  // ----------------------------------------------------------------------
  fault_flags u_fault_flags (
    .core_clk(core_clk),
    .rstn(rstn),
    .fault_set(fault_set),
    .fire_type(fire_type),
    .clear(clear_faults),
    .flags_q(fault_flags_q)
  );

  // ----------------------------------------------------------------------
  // bus monitoring
  // ----------------------------------------------------------------------
  assign wdog_enable = (bus_fail_mode != actuator_pkg::FAIL_LAST);
  assign wdog_renew = setpoint_renewed;

  bus_watchdog #(
    .LIMIT(WDOG_CYCLES)
  ) u_bus_watchdog (
    .core_clk(core_clk),
    .rstn(rstn),
    .enable(wdog_enable),
    .renew(wdog_renew),
    .tripped_q(wdog_tripped_q)
  );

  // fail drive requests follow the trip and the chosen position
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      fail_close_q <= 1'b0;
      fail_open_q <= 1'b0;
    end else begin
      fail_close_q <= wdog_tripped_q && (bus_fail_mode == actuator_pkg::FAIL_CLOSE); // RQ19
      fail_open_q <= wdog_tripped_q && (bus_fail_mode == actuator_pkg::FAIL_OPEN); // RQ19
    end
  end

  // ----------------------------------------------------------------------
  // local forced override
  // ----------------------------------------------------------------------
  // two-stage synchroniser for the control pin
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      y_meta_q <= 1'b0;
      y_sync_q <= 1'b0;
    end else begin
      y_meta_q <= y_switch_pin;
      y_sync_q <= y_meta_q;
    end
  end

  // override only while no sensor type is set
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      local_override_q <= 1'b0;
    end else begin
      local_override_q <= y_sync_q && (sensor_kind_q == actuator_pkg::SENSOR_NONE); // RQ17
    end
  end

endmodule

`default_nettype wire

// File: common/actuator_defines.svh
// offsets, field positions, reset values and timing counts of the register bank
`ifndef ACTUATOR_DEFINES_SVH
`define ACTUATOR_DEFINES_SVH

// ----------------------------------------------------------------------
// holding register offsets (word index)
// ----------------------------------------------------------------------
`define REG_COMMAND 16'h0003
`define REG_REL_POS 16'h0005
`define REG_ABS_POS 16'h0006
`define REG_REL_FLOW 16'h0007
`define REG_ABS_FLOW 16'h0008
`define REG_SENSOR 16'h0009
`define REG_SERIAL_1 16'h0065
`define REG_SERIAL_2 16'h0066
`define REG_SERIAL_4 16'h0067
`define REG_FIRMWARE 16'h0068
`define REG_STATUS 16'h0069
`define REG_MIN_LIMIT 16'h006a
`define REG_MAX_LIMIT 16'h006b
`define REG_SENSOR_KIND 16'h006c

// ----------------------------------------------------------------------
// value ranges and markers
// ----------------------------------------------------------------------
`define INVALID_WORD 16'hffff
`define PERCENT_FULL 16'h2710
`define MAX_LIMIT_FLOOR 16'h07d0
`define SENSOR_KIND_LAST 16'h0004

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define MIN_LIMIT_RESET 16'h0000
`define MAX_LIMIT_RESET 16'h2710
`define SENSOR_KIND_RESET 3'h0

// ----------------------------------------------------------------------
// status word fields
// ----------------------------------------------------------------------
`define ST_UTILISATION 0
`define ST_TRAVEL 1
`define ST_OVERLOAD 2
`define ST_UNUSED 3
`define ST_SAFETY 4
`define ST_FIRE_FIRST 5
`define ST_ACTIVITY 8
`define ST_GEAR 9
`define ST_WATCHDOG 10

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define CLK_HZ 64'd25000000
`define WDOG_TIME_S 64'd120
`define WDOG_CYCLES (`WDOG_TIME_S * `CLK_HZ)

`endif

// File: common/actuator_pkg.sv
// types shared by the actuator register bank
package actuator_pkg;

  // ----------------------------------------------------------------------
  // code enumerations
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    SENSOR_NONE = 3'h0,
    SENSOR_ACTIVE = 3'h1,
    SENSOR_PASSIVE_1K = 3'h2,
    SENSOR_PASSIVE_20K = 3'h3,
    SENSOR_CONTACT = 3'h4
  } sensor_kind_t;

  typedef enum logic [1:0] {
    ACT_UNKNOWN = 2'h0,
    ACT_DAMPER = 2'h1,
    ACT_FLOW_CTRL = 2'h2,
    ACT_FIRE = 2'h3
  } actuator_type_t;

  typedef enum logic [2:0] {
    CMD_NONE = 3'h0,
    CMD_ADAPTION = 3'h1,
    CMD_TEST_RUN = 3'h2,
    CMD_SYNC = 3'h3,
    CMD_RESET_FAULTS = 3'h4
  } command_t;

  typedef enum logic [1:0] {
    FAIL_LAST = 2'h0,
    FAIL_CLOSE = 2'h1,
    FAIL_OPEN = 2'h2
  } fail_mode_t;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_ANSWER = 2'b01
  } bus_state_t;

endpackage

// File: verilog/fault_flags.sv
// sticky malfunction flags of the status word low byte
`timescale 1ns/1ps
`default_nettype none
`include "actuator_defines.svh"

module fault_flags (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [7:0] fault_set,
  input wire logic fire_type,
  input wire logic clear,
  output logic [7:0] flags_q
);

  // ----------------------------------------------------------------------
  // one sticky flag per bit except bit 3, held at zero
  // ----------------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_flag
      // fire-only events count only on fire protection units
      localparam bit FIRE_ONLY = (i >= `ST_SAFETY);
      localparam bit KEEP = (i == `ST_UTILISATION) || (i == `ST_SAFETY);
      logic set_en;
      assign set_en = fault_set[i] && (!FIRE_ONLY || fire_type);
      // set wins over clear; bits 0 and 4 survive a clear
      always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
          flags_q[i] <= 1'b0;
        end else if (i == `ST_UNUSED) begin
          flags_q[i] <= 1'b0; // RQ9
        end else if (set_en) begin
          flags_q[i] <= 1'b1; // RQ9 RQ10
        end else if (clear && !KEEP) begin
          flags_q[i] <= 1'b0; // RQ13
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

// File: verilog/bus_watchdog.sv
// bus silence monitor that trips after a long period without renewal
`timescale 1ns/1ps
`default_nettype none

module bus_watchdog #(
  parameter logic [31:0] LIMIT = 32'd100
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic enable,
  input wire logic renew,
  output logic tripped_q
);

  logic [31:0] count_q;

  // ----------------------------------------------------------------------
  // silence counter, restarted by each renewal
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      count_q <= 32'h0000_0000;
    end else if (renew || !enable) begin
      count_q <= 32'h0000_0000; // RQ19
    end else if (count_q < LIMIT) begin
      count_q <= count_q + 32'h0000_0001;
    end
  end

  // trip flag held until the master renews or monitoring stops
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      tripped_q <= 1'b0;
    end else if (renew || !enable) begin
      tripped_q <= 1'b0;
    end else if (count_q >= LIMIT - 32'h0000_0001) begin
      tripped_q <= 1'b1; // RQ19
    end
  end

endmodule

`default_nettype wire

// File: dv/actuator_status_config_registers_props.sv
// port checker for the actuator register bank
`timescale 1ns/1ps
`default_nettype none

module actuator_status_config_registers_props (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic reg_req,
  input wire logic reg_we,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_ack_q,
  input wire logic reg_err_q,
  input wire logic [15:0] minimum_limit_q,
  input wire logic [15:0] maximum_limit_q,
  input wire logic [2:0] sensor_kind_q,
  input wire logic sensor_stale_q,
  input wire logic local_override_q,
  input wire logic [2:0] command_q,
  input wire logic setpoint_renewed,
  input wire logic [1:0] bus_fail_mode,
  input wire logic fail_close_q,
  input wire logic fail_open_q
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);

  // word indices that the bank answers
  function automatic logic mapped(input logic [15:0] a);
    return a == 16'h0003 || (a >= 16'h0005 && a <= 16'h0009) || (a >= 16'h0065 && a <= 16'h006c);
  endfunction

  // ----------------------------------------------------------------------
  // request shapes
  // ----------------------------------------------------------------------
  sequence cmd_clear_s;
    reg_req && reg_we && reg_addr == 16'h0003 && reg_wdata == 16'h0004;
  endsequence
  sequence kind_write_s;
    reg_req && reg_we && reg_addr == 16'h006c && reg_wdata <= 16'h0004;
  endsequence

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  ack_given_a: assert property (reg_req |=> reg_ack_q && $past(reg_req))
    else $error("request without answer");
  ack_idle_a: assert property (!reg_req |=> !reg_ack_q)
    else $error("answer without request");
  err_unmapped_a: assert property (reg_req && !mapped(reg_addr) |=> reg_err_q)
    else $error("unmapped word not flagged");
  err_mapped_a: assert property (reg_req && mapped(reg_addr) |=> !reg_err_q)
    else $error("mapped word flagged");
  max_range_a: assert property (maximum_limit_q >= 16'h07d0 && maximum_limit_q <= 16'h2710)
    else $error("maximum limit out of range");
  min_range_a: assert property (minimum_limit_q <= 16'h2710)
    else $error("minimum limit out of range");
  cmd_accept_a: assert property (cmd_clear_s |=> command_q == 3'h4)
    else $error("command not taken");
  cmd_return_a: assert property (command_q != 3'h0 |=> command_q == 3'h0)
    else $error("command not returned");
  kind_write_a: assert property (kind_write_s |=> sensor_kind_q == $past(reg_wdata[2:0]))
    else $error("sensor kind not stored");
  stale_mark_a: assert property ($changed(sensor_kind_q) |-> sensor_stale_q)
    else $error("kind change not marked stale");
  override_none_a: assert property (local_override_q |-> $past(sensor_kind_q) == 3'h0)
    else $error("override with sensor kind set");
  fail_mode_a: assert property (fail_close_q |-> $past(bus_fail_mode) == 2'h1 && !fail_open_q)
    else $error("close fail without mode");
  renew_clear_a: assert property (setpoint_renewed |-> ##2 !fail_close_q && !fail_open_q)
    else $error("renewal did not clear");
endmodule

bind actuator_status_config_registers actuator_status_config_registers_props props (.*);
`default_nettype wire

// File: dv/fieldbus_master_model.sv
// fieldbus master model issuing holding register accesses
`timescale 1ns/1ps
`default_nettype none

module fieldbus_master_model (
  input wire logic core_clk,
  output logic reg_req,
  output logic reg_we,
  output logic [15:0] reg_addr,
  output logic [15:0] reg_wdata,
  input wire logic reg_ack_q,
  input wire logic reg_err_q,
  input wire logic [15:0] reg_rdata_q
);
  // idle bus at time zero
  initial begin
    reg_req = 1'b0;
    reg_we = 1'b0;
    reg_addr = 16'h0000;
    reg_wdata = 16'h0000;
  end

  // one-cycle request pulse, answer taken in the cycle it stands
  task automatic access(input logic we, input logic [15:0] a, input logic [15:0] d,
                        output logic ok, output logic er, output logic [15:0] rd);
    @(negedge core_clk);
    reg_req = 1'b1;
    reg_we = we;
    reg_addr = a;
    reg_wdata = d;
    @(negedge core_clk);
    ok = reg_ack_q;
    er = reg_err_q;
    rd = reg_rdata_q;
    // released lines show the inverse, never a stale copy
    reg_req = 1'b0;
    reg_we = ~we;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
endmodule
`default_nettype wire

// File: dv/actuator_status_config_registers_test.sv
// self-checking bench for the actuator register bank
`timescale 1ns/1ps
`default_nettype none

module actuator_status_config_registers_test;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic reg_req, reg_we, reg_ack_q, reg_err_q;
  logic [15:0] reg_addr, reg_wdata, reg_rdata_q;
  logic [1:0] actuator_type = 2'h0;
  logic actuator_present = 1'b1;
  logic [15:0] rel_position_in = 16'h0000;
  logic [15:0] abs_position_in = 16'h0000;
  logic [15:0] rel_flow_in = 16'h0000;
  logic [15:0] abs_flow_in = 16'h0000;
  logic [15:0] sensor_value_in = 16'h0000;
  logic [7:0] fault_set = 8'h00;
  logic internal_activity = 1'b0;
  logic gear_disengaged = 1'b0;
  logic setpoint_renewed = 1'b0;
  logic [1:0] bus_fail_mode = 2'h0;
  logic y_switch_pin = 1'b0;
  logic [15:0] minimum_limit_q, maximum_limit_q;
  logic [2:0] sensor_kind_q, command_q;
  logic sensor_stale_q, local_override_q, fail_close_q, fail_open_q;
  int fails = 0;
  int checks_done = 0;
  logic [15:0] lim [5][3] = '{'{16'h006a, 16'h1388, 16'h1388}, '{16'h006a, 16'h3000, 16'h2710},
    '{16'h006b, 16'h0100, 16'h07d0}, '{16'h006b, 16'h2ee0, 16'h2710},
    '{16'h006b, 16'h07d0, 16'h07d0}};

  // 25 MHz clock
  always #20 core_clk = ~core_clk;

  // serial and firmware values are arbitrary
  actuator_status_config_registers #(.WDOG_CYCLES(32'd20), .SERIAL_PART_1(16'h1a2b),
    .SERIAL_PART_2(16'h3c4d), .SERIAL_PART_4(16'h5e6f), .FIRMWARE_VERSION(16'h0123)) dut (.*);

  fieldbus_master_model bus (.*);

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic xfer(input logic we, input logic [15:0] a, input logic [15:0] d,
                      input logic [15:0] st, input logic [15:0] exp, input logic cmp);
    logic ok, er;
    logic [15:0] q;
    bus.access(we, a, d, ok, er, q);
    check({14'h0, ok, er}, st);
    if (cmp) check(q, exp);
  endtask

  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    xfer(1'b0, a, 16'h0000, 16'h0002, exp, 1'b1);
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] v);
    xfer(1'b1, a, v, 16'h0002, 16'h0000, 1'b0);
  endtask

  task automatic cycles(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  task automatic pulse_fault(input logic [7:0] v);
    @(negedge core_clk);
    fault_set = v;
    @(negedge core_clk);
    fault_set = 8'h00;
  endtask

  task automatic do_reset();
    rstn = 1'b0;
    cycles(2);
    rstn = 1'b1;
  endtask

  task automatic end_sim();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // hang guard
  initial begin
    #400000;
    fails++;
    end_sim();
  end

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    do_reset();
    check(minimum_limit_q, 16'h0000);
    check(maximum_limit_q, 16'h2710);
    check({13'h0, sensor_kind_q}, 16'h0000);
    rel_position_in = 16'h1388;
    abs_position_in = 16'h005a;
    rel_flow_in = 16'h2710;
    abs_flow_in = 16'h01f4;
    actuator_type = 2'h2;
    rd(16'h0005, 16'h1388);
    rd(16'h0006, 16'h005a);
    rd(16'h0007, 16'h2710);
    rd(16'h0008, 16'h01f4);
    actuator_type = 2'h1;
    actuator_present = 1'b0;
    rd(16'h0006, 16'hffff);
    rd(16'h0007, 16'hffff);
    rd(16'h0008, 16'hffff);
    rd(16'h0065, 16'h1a2b);
    rd(16'h0066, 16'h3c4d);
    rd(16'h0067, 16'h5e6f);
    rd(16'h0068, 16'h0123);
    wr(16'h0005, 16'h0000);
    rd(16'h0005, 16'h1388);
    xfer(1'b0, 16'h0004, 16'h0000, 16'h0003, 16'h0000, 1'b0);
    xfer(1'b1, 16'h006d, 16'h0001, 16'h0003, 16'h0000, 1'b0);
    // limits with clamping at both ends
    for (int i = 0; i < 5; i++) begin
      wr(lim[i][0], lim[i][1]);
      rd(lim[i][0], lim[i][2]);
    end
    check(maximum_limit_q, 16'h07d0);
    // status word and fault clearing
    actuator_type = 2'h3;
    internal_activity = 1'b1;
    gear_disengaged = 1'b1;
    pulse_fault(8'hff);
    rd(16'h0069, 16'h03f7);
    internal_activity = 1'b0;
    gear_disengaged = 1'b0;
    wr(16'h0003, 16'h0004);
    check({13'h0, command_q}, 16'h0004);
    cycles(1);
    check({13'h0, command_q}, 16'h0000);
    rd(16'h0069, 16'h0011);
    actuator_type = 2'h1;
    pulse_fault(8'he2);
    rd(16'h0069, 16'h0013);
    // sensor kind and local override
    rd(16'h0009, 16'h0000);
    y_switch_pin = 1'b1;
    cycles(4);
    check({15'h0, local_override_q}, 16'h0001);
    wr(16'h006c, 16'h0001);
    cycles(3);
    check({15'h0, local_override_q}, 16'h0000);
    rd(16'h006c, 16'h0001);
    rd(16'h0009, 16'hffff);
    check({15'h0, sensor_stale_q}, 16'h0001);
    wr(16'h006c, 16'h0007);
    rd(16'h006c, 16'h0001);
    // bus silence in both fail modes
    bus_fail_mode = 2'h1;
    cycles(18);
    check({15'h0, fail_close_q}, 16'h0000);
    cycles(6);
    check({15'h0, fail_close_q}, 16'h0001);
    rd(16'h0069, 16'h0413);
    setpoint_renewed = 1'b1;
    cycles(1);
    setpoint_renewed = 1'b0;
    cycles(2);
    check({15'h0, fail_close_q}, 16'h0000);
    bus_fail_mode = 2'h2;
    cycles(25);
    check({15'h0, fail_open_q}, 16'h0001);
    bus_fail_mode = 2'h0;
    cycles(3);
    check({15'h0, fail_open_q}, 16'h0000);
    // restart brings the sensor back to none
    do_reset();
    check({15'h0, sensor_stale_q}, 16'h0000);
    rd(16'h0009, 16'h0000);
    end_sim();
  end
endmodule
`default_nettype wire
